// *** pkg/data_move_pkg.sv ***
// constants and operation codes for the data-move execution block
package data_move_pkg;
    localparam int BYTE_W = 8;
    localparam int WORD_W = 16;
    localparam int DWORD_W = 32;
    localparam int DWORD_LOW_MSB = 15;
    localparam int SIGN_BIT = 7;
    localparam logic [15:0] PC_RESET = 16'h0000;
    localparam logic [15:0] POINTER_RESET = 16'h0000;
    localparam logic [7:0] ACC_RESET = 8'h00;
    localparam logic [7:0] PORT_TWO_RESET = 8'hFF;
    localparam logic [4:0] FLAGS_RESET = 5'h00;
    localparam logic [15:0] PC_STEP_ONE = 16'h0001;

    typedef enum logic [7:0] {
        OP_NONE            = 8'h01,
        OP_LOAD_POINTER    = 8'h02,
        OP_CODE_BYTE_PC    = 8'h04,
        OP_CODE_BYTE_PTR   = 8'h08,
        OP_HIGH_WORD_IMM   = 8'h10,
        OP_SIGN_EXTEND     = 8'h20,
        OP_EXT_INDIRECT    = 8'h40,
        OP_EXT_POINTER     = 8'h80
    } move_op_e;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_FETCH = 3'b010,
        ST_EXT   = 3'b100
    } exec_state_e;
endpackage

// *** src/data_move_instruction_exec.sv ***
// execution unit for pointer load, code-byte, high-word, sign-extend and external moves
`timescale 1ns/1ps
module data_move_instruction_exec
    import data_move_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic op_valid,
    input wire logic [7:0] op_code,
    input wire logic [15:0] op_imm,
    input wire logic op_ptr_sel,
    input wire logic [7:0] byte_register,
    input wire logic [31:0] dword_register_in,
    input wire logic [15:0] pc_next_instr,
    input wire logic [7:0] indirect_pointer_zero,
    input wire logic [7:0] indirect_pointer_one,
    input wire logic ext_write,
    input wire logic [7:0] code_data,
    input wire logic code_ready,
    input wire logic [7:0] ext_rdata,
    input wire logic ext_ready,
    input wire logic [7:0] port_two_latch,
    output logic op_ready,
    output logic [15:0] data_pointer,
    output logic [7:0] acc,
    output logic [15:0] pc,
    output logic [4:0] flags,
    output logic [31:0] dword_register_out,
    output logic dword_we,
    output logic [15:0] word_register_out,
    output logic word_we,
    output logic code_req,
    output logic [15:0] code_addr,
    output logic ext_req,
    output logic ext_we,
    output logic [7:0] port_zero_out,
    output logic [7:0] port_two_out,
    output logic [7:0] ext_wdata
);
    exec_state_e state_reg;
    logic [15:0] pointer_reg;
    logic [7:0] acc_reg;
    logic [15:0] pc_reg;
    logic [4:0] flags_reg;
    logic ext_is_read_reg;

    // zero-extend accumulator and add to base
    function automatic logic [15:0] code_sum(input logic [7:0] a, input logic [15:0] base);
        return base + {8'h00, a};
    endfunction

    wire logic take = op_valid && (state_reg == ST_IDLE);
    assign op_ready = (state_reg == ST_IDLE);
    assign data_pointer = pointer_reg;
    assign acc = acc_reg;
    assign pc = pc_reg;
    assign flags = flags_reg;
    assign flags_reg = FLAGS_RESET;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_reg <= ST_IDLE;
            ext_is_read_reg <= 1'b0;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    if (take && (op_code == OP_CODE_BYTE_PC || op_code == OP_CODE_BYTE_PTR)) begin
                        state_reg <= ST_FETCH;
                    end else if (take && (op_code == OP_EXT_INDIRECT || op_code == OP_EXT_POINTER)) begin
                        state_reg <= ST_EXT;
                        ext_is_read_reg <= !ext_write;
                    end
                end
                ST_FETCH: begin
                    if (code_ready) state_reg <= ST_IDLE;
                end
                ST_EXT: begin
                    if (ext_ready) state_reg <= ST_IDLE;
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pointer_reg <= POINTER_RESET;
        end else if (take && op_code == OP_LOAD_POINTER) begin
            pointer_reg <= {op_imm[15:8], op_imm[7:0]};
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pc_reg <= PC_RESET;
        end else if (take) begin
            pc_reg <= pc_next_instr;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            code_req <= 1'b0;
            code_addr <= 16'h0000;
        end else if (take && op_code == OP_CODE_BYTE_PC) begin
            code_req <= 1'b1;
            code_addr <= code_sum(acc_reg, pc_next_instr);
        end else if (take && op_code == OP_CODE_BYTE_PTR) begin
            code_req <= 1'b1;
            code_addr <= code_sum(acc_reg, pointer_reg);
        end else if (code_ready) begin
            code_req <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            acc_reg <= ACC_RESET;
        end else if (state_reg == ST_FETCH && code_ready) begin
            acc_reg <= code_data;
        end else if (state_reg == ST_EXT && ext_ready && ext_is_read_reg) begin
            acc_reg <= ext_rdata;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            dword_we <= 1'b0;
            dword_register_out <= 32'h0000_0000;
        end else begin
            dword_we <= take && op_code == OP_HIGH_WORD_IMM;
            dword_register_out <= {op_imm, dword_register_in[DWORD_LOW_MSB:0]};
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            word_we <= 1'b0;
            word_register_out <= 16'h0000;
        end else begin
            word_we <= take && op_code == OP_SIGN_EXTEND;
            word_register_out <= {{8{byte_register[SIGN_BIT]}}, byte_register};
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ext_req <= 1'b0;
            ext_we <= 1'b0;
            port_zero_out <= 8'h00;
            port_two_out <= PORT_TWO_RESET;
            ext_wdata <= 8'h00;
        end else if (take && op_code == OP_EXT_INDIRECT) begin
            ext_req <= 1'b1;
            ext_we <= ext_write;
            ext_wdata <= acc_reg;
            port_zero_out <= op_ptr_sel ? indirect_pointer_one : indirect_pointer_zero;
            port_two_out <= port_two_latch;
        end else if (take && op_code == OP_EXT_POINTER) begin
            ext_req <= 1'b1;
            ext_we <= ext_write;
            ext_wdata <= acc_reg;
            port_zero_out <= pointer_reg[7:0];
            port_two_out <= pointer_reg[15:8];
        end else begin
            if (ext_ready) begin
                ext_req <= 1'b0;
                ext_we <= 1'b0;
            end
            if (state_reg == ST_IDLE) port_two_out <= port_two_latch;
        end
    end

    AST_PTR_LOAD: assert property (@(posedge clk) disable iff (sys_rst)
        take && op_code == OP_LOAD_POINTER |=> data_pointer == $past(op_imm))
        else $error("pointer load mismatch");
    AST_PC_BASE: assert property (@(posedge clk) disable iff (sys_rst)
        take && op_code == OP_CODE_BYTE_PC |=>
        code_addr == $past(pc_next_instr) + {8'h00, $past(acc_reg)} && pc == $past(pc_next_instr))
        else $error("pc relative base wrong");
    sequence fetch_done_s;
        state_reg == ST_FETCH && code_ready;
    endsequence
    AST_CODE_ACC: assert property (@(posedge clk) disable iff (sys_rst)
        fetch_done_s |=> acc == $past(code_data))
        else $error("code byte not loaded");
    // a pending fetch or external access keeps its address steady until answered
    sequence fetch_wait_s;
        code_req && !code_ready;
    endsequence
    AST_CODE_HOLD: assert property (@(posedge clk) disable iff (sys_rst)
        fetch_wait_s |=> code_req && $stable(code_addr))
        else $error("code address moved while waiting");
    AST_HIGH_WORD: assert property (@(posedge clk) disable iff (sys_rst)
        take && op_code == OP_HIGH_WORD_IMM |=> dword_we
        && dword_register_out == {$past(op_imm), $past(dword_register_in[15:0])})
        else $error("high word move wrong");
    AST_SIGN_EXT: assert property (@(posedge clk) disable iff (sys_rst)
        take && op_code == OP_SIGN_EXTEND |=> word_we
        && word_register_out[15:8] == {8{$past(byte_register[7])}}
        && word_register_out[7:0] == $past(byte_register))
        else $error("sign extension wrong");
    AST_EXT_IND: assert property (@(posedge clk) disable iff (sys_rst)
        take && op_code == OP_EXT_INDIRECT |=> ext_req && port_zero_out ==
        ($past(op_ptr_sel) ? $past(indirect_pointer_one) : $past(indirect_pointer_zero)))
        else $error("indirect address wrong");
    AST_EXT_PTR: assert property (@(posedge clk) disable iff (sys_rst)
        take && op_code == OP_EXT_POINTER |=> ext_req
        && {port_two_out, port_zero_out} == $past(pointer_reg))
        else $error("pointer address wrong");
    sequence ext_wait_s;
        ext_req && !ext_ready;
    endsequence
    AST_EXT_HOLD: assert property (@(posedge clk) disable iff (sys_rst)
        ext_wait_s |=> ext_req && $stable(port_zero_out) && $stable(port_two_out))
        else $error("external address moved while waiting");
    AST_PORT_TWO_KEEP: assert property (@(posedge clk) disable iff (sys_rst)
        take && op_code == OP_EXT_INDIRECT |=> port_two_out == $past(port_two_latch))
        else $error("port two not latch value");
    AST_PORT_TWO_IDLE: assert property (@(posedge clk) disable iff (sys_rst)
        state_reg == ST_IDLE && !take |=> port_two_out == $past(port_two_latch))
        else $error("port two not following latch while idle");
    AST_FLAGS: assert property (@(posedge clk) disable iff (sys_rst)
        take |=> $stable(flags))
        else $error("flags changed");
    AST_PC_HOLD: assert property (@(posedge clk) disable iff (sys_rst)
        !take |=> $stable(pc))
        else $error("program counter changed without a move");
endmodule

// *** testbench/ext_ram_model.sv ***
// code memory and external data ram answering the execution block
`timescale 1ns/1ps
module ext_ram_model (
    input wire logic clk,
    input wire logic slow,
    input wire logic code_req,
    input wire logic [15:0] code_addr,
    output logic [7:0] code_data,
    output logic code_ready,
    input wire logic ext_req,
    input wire logic ext_we,
    input wire logic [15:0] ext_addr,
    input wire logic [7:0] ext_wdata,
    output logic [7:0] ext_rdata,
    output logic ext_ready
);
    logic [7:0] mem [0:65535];
    logic [2:0] ccnt = 3'h0;
    logic [2:0] ecnt = 3'h0;
    logic [2:0] dly;
    assign dly = slow ? 3'h3 : 3'h0;
    initial begin
        code_ready = 1'b0;
        ext_ready = 1'b0;
        for (int i = 0; i < 65536; i++) mem[i] = i[7:0] ^ i[15:8] ^ 8'hA5;
    end
    // data lines with no request pending show the inverse of their last value
    always @(posedge clk) begin
        ccnt <= code_req ? ccnt + {2'b00, ccnt <= dly} : 3'h0;
        code_ready <= code_req && ccnt == dly;
        code_data <= code_req ? code_addr[7:0] ^ code_addr[15:8] ^ 8'h3C : ~code_data;
        ecnt <= ext_req ? ecnt + {2'b00, ecnt <= dly} : 3'h0;
        ext_ready <= ext_req && ecnt == dly;
        ext_rdata <= ext_req ? mem[ext_addr] : ~ext_rdata;
        if (ext_req && ext_we && ecnt == dly) mem[ext_addr] <= ext_wdata;
    end
endmodule

// *** testbench/test_data_move_instruction_exec.sv ***
// self-checking bench for the data-move execution block
`timescale 1ns/1ps
module test_data_move_instruction_exec;
    import data_move_pkg::*;
    logic clk = 1'b0, sys_rst = 1'b1, op_valid = 1'b0, sel = 1'b0, ext_write = 1'b0, slow = 1'b0;
    logic [7:0] op_code = 8'h01, br = 8'h00, ip0 = 8'h00, ip1 = 8'h00, p2l = 8'hFF, wacc;
    logic [15:0] op_imm = 16'h0000, pcn = 16'h0000;
    logic [31:0] dwi = 32'h00000000;
    logic op_ready, code_req, code_ready, ext_req, ext_we, ext_ready, dword_we, word_we;
    logic [7:0] acc, code_data, ext_rdata, addr_lo, addr_hi, wd;
    logic [15:0] data_ptr, pc, code_addr, wro;
    logic [7:0] exp_acc = 8'h00;
    logic [4:0] flags;
    logic [31:0] dwo;
    int n_errors = 0, n_checks = 0;
    data_move_instruction_exec u_dut (.clk(clk), .sys_rst(sys_rst), .op_valid(op_valid),
        .op_code(op_code), .op_imm(op_imm), .op_ptr_sel(sel), .byte_register(br),
        .dword_register_in(dwi), .pc_next_instr(pcn), .indirect_pointer_zero(ip0),
        .indirect_pointer_one(ip1), .ext_write(ext_write), .code_data(code_data),
        .code_ready(code_ready), .ext_rdata(ext_rdata), .ext_ready(ext_ready),
        .port_two_latch(p2l), .op_ready(op_ready), .data_pointer(data_ptr), .acc(acc), .pc(pc),
        .flags(flags), .dword_register_out(dwo), .dword_we(dword_we), .word_register_out(wro),
        .word_we(word_we), .code_req(code_req), .code_addr(code_addr), .ext_req(ext_req),
        .ext_we(ext_we), .port_zero_out(addr_lo), .port_two_out(addr_hi), .ext_wdata(wd));
    ext_ram_model u_mem (.clk(clk), .slow(slow), .code_req(code_req), .code_addr(code_addr),
        .code_data(code_data), .code_ready(code_ready), .ext_req(ext_req), .ext_we(ext_we),
        .ext_addr({addr_hi, addr_lo}), .ext_wdata(wd), .ext_rdata(ext_rdata), .ext_ready(ext_ready));
    initial begin
        forever #4 clk = ~clk;
    end
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic final_report();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic wait_idle();
        for (int i = 0; i < 40; i++) begin
            @(posedge clk);
            #1;
            if (op_ready === 1'b1) return;
        end
        n_errors++;
        final_report();
    endtask
    // one accepted request, then settle past the taking edge
    task automatic issue(input logic [7:0] op, input logic [15:0] imm);
        wait_idle();
        @(posedge clk);
        op_valid <= 1'b1;
        op_code <= op;
        op_imm <= imm;
        @(posedge clk);
        op_valid <= 1'b0;
        #1;
    endtask
    task automatic s_code(input logic use_pc, input logic [15:0] base);
        logic [15:0] a;
        a = base + {8'h00, exp_acc};
        issue(use_pc ? OP_CODE_BYTE_PC : OP_CODE_BYTE_PTR, 16'h0000);
        chk("code_addr", {16'h0000, a}, {16'h0000, code_addr});
        if (use_pc) chk("pc", {16'h0000, base}, {16'h0000, pc});
        wait_idle();
        exp_acc = a[7:0] ^ a[15:8] ^ 8'h3C;
        chk("acc", {24'h000000, exp_acc}, {24'h000000, acc});
    endtask
    task automatic s_ext(input logic [7:0] op, input logic [15:0] addr, input logic [7:0] exp);
        issue(op, 16'h0000);
        chk("ext_addr", {16'h0000, addr}, {16'h0000, addr_hi, addr_lo});
        chk("ext_we", {31'h0, ext_write}, {31'h0, ext_we});
        wait_idle();
        if (!ext_write) chk("acc", {24'h000000, exp}, {24'h000000, acc});
    endtask
    initial begin
        #400000;
        n_errors++;
        final_report();
    end
    initial begin
        static logic [7:0] v [4] = '{8'h55, 8'h80, 8'hFF, 8'h7F};
        repeat (20) @(posedge clk);
        sys_rst <= 1'b0;
        issue(OP_LOAD_POINTER, 16'h1234);
        issue(OP_LOAD_POINTER, 16'hC334);
        chk("data_ptr", 32'h0000C334, {16'h0000, data_ptr});
        @(posedge clk);
        dwi <= 32'h55667788;
        issue(OP_HIGH_WORD_IMM, 16'h1122);
        chk("dword", 32'h11227788, dwo);
        chk("dword_we", 32'h00000001, {31'h0, dword_we});
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            br <= v[i];
            issue(OP_SIGN_EXTEND, 16'h0000);
            chk("word", {16'h0000, {8{v[i][7]}}, v[i]}, {16'h0000, wro});
            chk("word_we", 32'h00000001, {31'h0, word_we});
        end
        s_code(1'b0, 16'hC334);
        @(posedge clk);
        slow <= 1'b1;
        pcn <= 16'hFFF0;
        s_code(1'b1, 16'hFFF0);
        @(posedge clk);
        slow <= 1'b0;
        ip1 <= 8'h34;
        sel <= 1'b1;
        p2l <= 8'hC3;
        ext_write <= 1'b1;
        wacc = exp_acc;
        s_ext(OP_EXT_INDIRECT, 16'hC334, 8'h00);
        @(posedge clk);
        ext_write <= 1'b0;
        slow <= 1'b1;
        s_ext(OP_EXT_POINTER, 16'hC334, wacc);
        @(posedge clk);
        ip0 <= 8'h12;
        sel <= 1'b0;
        p2l <= 8'h5A;
        s_ext(OP_EXT_INDIRECT, 16'h5A12, 8'h12 ^ 8'h5A ^ 8'hA5);
        issue(OP_NONE, 16'hFFFF);
        chk("data_ptr_kept", 32'h0000C334, {16'h0000, data_ptr});
        chk("acc_kept", 32'h000000ED, {24'h000000, acc});
        chk("flags", 32'h00000000, {27'h0, flags});
        final_report();
    end
endmodule
